/* File: pfp_consts.vh */
// Constants for the fault-protection manager: register map, fields, timing
`ifndef PFP_CONSTS_VH
`define PFP_CONSTS_VH
`define PFP_ADDR_CTRL 8'h00
`define PFP_ADDR_STATUS 8'h04
`define PFP_ADDR_IRQ_STAT 8'h08
`define PFP_ADDR_IRQ_MASK 8'h0C
`define PFP_ADDR_FAULTS 8'h10
`define PFP_ADDR_SCP_TIME 8'h14
`define PFP_CTRL_RESET 32'h0000_0001
`define PFP_CTRL_EN_BIT 0
`define PFP_CTRL_EXT_OTP_BIT 1
`define PFP_MODE_NORMAL 4'h1
`define PFP_MODE_AUTO 4'h2
`define PFP_MODE_FAST 4'h4
`define PFP_MODE_HOLD 4'h8
`define PFP_EV_AUTO 0
`define PFP_EV_FAST 1
`define PFP_EV_HOLD 2
`define PFP_EV_RESTART 3
`define PFP_EV_CLEAR 4
`define PFP_CLK_HZ 25000000
`define PFP_SCP_TIME_US 32'd50000
`define PFP_SCP_CYCLES (`PFP_SCP_TIME_US * (`PFP_CLK_HZ / 1000000))
`endif

/* File: pfp_qualify.v */
// Counts how long a level stays asserted and flags when a limit is reached
module pfp_qualify #(
    parameter WIDTH = 32
) (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire level,
    input wire [WIDTH-1:0] limit,
    output reg done
);
    reg [WIDTH-1:0] count;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (clear || !level)
        begin
            count <= {WIDTH{1'b0}};
            done <= 1'b0;
        end
        else if (count + 1'b1 >= limit)
        begin
            done <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
        end
    end
endmodule

/* File: pfp_pulse_pair.v */
// Detects a saturation flag on two consecutive switching pulses
module pfp_pulse_pair (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire pulse_end,
    input wire over_ref,
    output reg trip
);
    reg prev_over;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_over <= 1'b0;
            trip <= 1'b0;
        end
        else if (clear)
        begin
            prev_over <= 1'b0;
            trip <= 1'b0;
        end
        else if (pulse_end)
        begin
            prev_over <= over_ref;
            trip <= prev_over && over_ref;
        end
        else
        begin
            trip <= 1'b0;
        end
    end
endmodule

/* File: pfp_fault_fsm.v */
// Fault-protection manager: mode selection, switching gate, supply draw, AHB-Lite registers
`include "pfp_consts.vh"
module pfp_fault_fsm #(
    parameter SCP_CYCLES = `PFP_SCP_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire supply_ovp,
    input wire fb_ovp,
    input wire fb_below_scp,
    input wire fb_open,
    input wire cs_res_fault,
    input wire sat_over_ref,
    input wire pulse_end,
    input wire junction_hot,
    input wire junction_cooled,
    input wire ext_temp_trip,
    input wire ext_temp_recover,
    input wire thermistor_present,
    input wire supply_at_startup,
    input wire supply_at_min,
    input wire pulse_req,
    output reg gate_out,
    output reg standby_draw,
    output reg supply_hold_floor,
    output reg restart_req,
    output reg [3:0] prot_mode,
    output reg irq
);
    localparam S_OFF = 4'h1;
    localparam S_RUN = 4'h2;
    localparam S_WAIT = 4'h4;
    localparam S_HOLD = 4'h8;

    reg [3:0] state;
    reg [3:0] mode;
    reg [31:0] ctrl;
    reg [4:0] irq_stat;
    reg [4:0] irq_mask;
    reg [31:0] scp_limit;
    reg junction_latched;
    reg ext_latched;
    reg wr_pending;
    reg [7:0] wr_addr;
    reg [4:0] events;
    reg [4:0] next_irq_stat;
    reg [31:0] rd_value;
    wire scp_done;
    wire sat_trip;
    wire enable;
    wire ext_otp_en;
    wire auto_fault;
    wire fast_fault;
    wire hold_fault;
    wire hold_active;
    wire bus_take;

    assign enable = ctrl[`PFP_CTRL_EN_BIT];
    assign ext_otp_en = ctrl[`PFP_CTRL_EXT_OTP_BIT] && thermistor_present;
    assign bus_take = hsel && hready && htrans[1];

    // Window opens only once the supply has reached startup level and switching runs
    pfp_qualify #(
        .WIDTH(32)
    ) u_scp (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(state != S_RUN),
        .level(fb_below_scp),
        .limit(scp_limit),
        .done(scp_done)
    );

    pfp_pulse_pair u_sat (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(state != S_RUN),
        .pulse_end(pulse_end),
        .over_ref(sat_over_ref),
        .trip(sat_trip)
    );

    // Temperature faults stay latched until their recovery condition; the external one also clears while ext_otp_en is low
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            junction_latched <= 1'b0;
            ext_latched <= 1'b0;
        end
        else
        begin
            if (junction_hot)
                junction_latched <= 1'b1;
            else if (junction_cooled)
                junction_latched <= 1'b0;
            if (!ext_otp_en)
                ext_latched <= 1'b0;
            else if (ext_temp_trip)
                ext_latched <= 1'b1;
            else if (ext_temp_recover)
                ext_latched <= 1'b0;
        end
    end

    assign hold_fault = junction_hot || (ext_otp_en && ext_temp_trip);
    assign hold_active = junction_latched || ext_latched || hold_fault;
    assign fast_fault = fb_open || cs_res_fault || sat_trip;
    assign auto_fault = supply_ovp || fb_ovp || scp_done;

    // Protection state machine
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= S_OFF;
            mode <= `PFP_MODE_NORMAL;
            events <= 5'h00;
        end
        else
        begin
            events <= 5'h00;
            case (state)
                S_OFF:
                begin
                    if (enable && supply_at_startup && !hold_active)
                    begin
                        state <= S_RUN;
                        mode <= `PFP_MODE_NORMAL;
                    end
                end
                S_RUN:
                begin
                    if (!enable)
                        state <= S_OFF;
                    else if (hold_active)
                    begin
                        state <= S_HOLD;
                        mode <= `PFP_MODE_HOLD;
                        events[`PFP_EV_HOLD] <= 1'b1;
                    end
                    else if (fast_fault)
                    begin
                        state <= S_WAIT;
                        mode <= `PFP_MODE_FAST;
                        events[`PFP_EV_FAST] <= 1'b1;
                    end
                    else if (auto_fault)
                    begin
                        state <= S_WAIT;
                        mode <= `PFP_MODE_AUTO;
                        events[`PFP_EV_AUTO] <= 1'b1;
                    end
                end
                S_WAIT:
                begin
                    if (hold_active)
                    begin
                        state <= S_HOLD;
                        mode <= `PFP_MODE_HOLD;
                        events[`PFP_EV_HOLD] <= 1'b1;
                    end
                    else if (supply_at_min)
                    begin
                        state <= S_OFF;
                        events[`PFP_EV_RESTART] <= 1'b1;
                    end
                end
                S_HOLD:
                begin
                    if (!hold_active)
                    begin
                        state <= S_OFF;
                        mode <= `PFP_MODE_NORMAL;
                        events[`PFP_EV_CLEAR] <= 1'b1;
                    end
                end
                default:
                begin
                    state <= S_OFF;
                end
            endcase
        end
    end

    // Output stage: registered gate, blocked from the edge after this cycle's faults
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            gate_out <= 1'b0;
            standby_draw <= 1'b0;
            supply_hold_floor <= 1'b0;
            restart_req <= 1'b0;
            prot_mode <= `PFP_MODE_NORMAL;
        end
        else
        begin
            gate_out <= pulse_req && (state == S_RUN) && enable && !hold_active
                && !fast_fault && !auto_fault;
            standby_draw <= (state == S_WAIT) && (mode == `PFP_MODE_AUTO);
            supply_hold_floor <= (state == S_HOLD);
            restart_req <= (state == S_WAIT) && supply_at_min;
            prot_mode <= mode;
        end
    end

    // Sticky status: a new event wins over a write-one clear
    always @*
    begin
        next_irq_stat = irq_stat;
        if (wr_pending && wr_addr == `PFP_ADDR_IRQ_STAT)
            next_irq_stat = irq_stat & ~hwdata[4:0];
        next_irq_stat = next_irq_stat | events;
    end

    always @*
    begin
        rd_value = 32'h0000_0000;
        if (haddr == `PFP_ADDR_CTRL)
            rd_value = ctrl;
        else if (haddr == `PFP_ADDR_STATUS)
            rd_value = {24'h00_0000, state, mode};
        else if (haddr == `PFP_ADDR_IRQ_STAT)
            rd_value = {27'h000_0000, next_irq_stat};
        else if (haddr == `PFP_ADDR_IRQ_MASK)
            rd_value = {27'h000_0000, irq_mask};
        else if (haddr == `PFP_ADDR_FAULTS)
            rd_value = {21'h00_0000, thermistor_present, ext_latched, junction_latched,
                sat_trip, scp_done, cs_res_fault, fb_open, fb_below_scp, fb_ovp, supply_ovp};
        else if (haddr == `PFP_ADDR_SCP_TIME)
            rd_value = scp_limit;
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= `PFP_CTRL_RESET;
            irq_mask <= 5'h00;
            irq_stat <= 5'h00;
            scp_limit <= 32'h0000_0000;
            wr_pending <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            wr_pending <= bus_take && hwrite;
            wr_addr <= haddr;
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            if (bus_take && !hwrite)
                hrdata <= rd_value;
            if (wr_pending)
            begin
                if (wr_addr == `PFP_ADDR_CTRL)
                    ctrl <= {30'h0000_0000, hwdata[1:0]};
                else if (wr_addr == `PFP_ADDR_IRQ_MASK)
                    irq_mask <= hwdata[4:0];
                else if (wr_addr == `PFP_ADDR_SCP_TIME)
                    scp_limit <= hwdata;
            end
            else if (scp_limit == 32'h0000_0000)
                scp_limit <= SCP_CYCLES;
        end
    end
endmodule

/* File: pfp_analog_model.sv */
// Supply rail and switching-pulse model around the fault manager
module pfp_analog_model (
    input wire hclk,
    input wire hresetn,
    input wire gate_out,
    input wire standby_draw,
    input wire supply_hold_floor,
    input wire restart_req,
    output logic pulse_req,
    output logic pulse_end,
    output wire supply_at_startup,
    output wire supply_at_min
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] level;
    logic [1:0] slot;
    assign supply_at_startup = level >= 6'd40;
    assign supply_at_min = level <= 6'd8;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            level <= 6'd40;
            slot <= 2'd0;
            pulse_req <= 1'b0;
            pulse_end <= 1'b0;
        end
        else
        begin
            slot <= slot + 2'd1;
            pulse_req <= slot == 2'd0;
            pulse_end <= gate_out;
            // Pulses feed the auxiliary winding; a restart recharges to startup
            // Startup path also recharges an idle rail once it reaches the minimum level
            if (restart_req || gate_out)
                level <= 6'd40;
            else if (!supply_hold_floor && level <= 6'd8)
                level <= 6'd40;
            else if (supply_hold_floor && level <= 6'd12)
                level <= level;
            else if (level != 6'd0 && (!standby_draw || slot == 2'd0))
                level <= level - 6'd1;
        end
    end
endmodule

/* File: pfp_fault_monitor.sv */
// Port-level checker for the fault-protection manager
module pfp_fault_monitor (
    input wire hclk,
    input wire hresetn,
    input wire supply_ovp,
    input wire fb_ovp,
    input wire fb_open,
    input wire cs_res_fault,
    input wire sat_over_ref,
    input wire pulse_end,
    input wire junction_hot,
    input wire ext_temp_trip,
    input wire supply_at_min,
    input wire gate_out,
    input wire standby_draw,
    input wire supply_hold_floor,
    input wire restart_req,
    input wire [3:0] prot_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_sat;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Saturation flag of the previous pulse within the current run
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
            prev_sat <= 1'b0;
        else if (prot_mode != 4'h1)
            prev_sat <= 1'b0;
        else if (pulse_end)
            prev_sat <= sat_over_ref;
    a_fault_stops_gate: assert property ((supply_ovp || fb_ovp || fb_open || cs_res_fault)
        |=> !gate_out) else $error("gate pulse after fault");
    a_auto_entry_ovp: assert property ((fb_ovp && gate_out && !fb_open && !cs_res_fault
        && !sat_over_ref && !junction_hot && !ext_temp_trip) |-> ##2 (prot_mode == 4'h2))
        else $error("no auto-recovery after overvoltage");
    a_auto_standby: assert property ($rose(prot_mode == 4'h2) |-> standby_draw)
        else $error("auto-recovery without standby draw");
    a_fast_draw: assert property ($rose(prot_mode == 4'h4) |-> !standby_draw)
        else $error("fast-recovery with standby draw");
    a_hold_floor: assert property ($rose(prot_mode == 4'h8) |-> supply_hold_floor)
        else $error("hold without supply floor");
    a_hold_no_gate: assert property ((prot_mode == 4'h8) |-> !gate_out)
        else $error("gate pulse in hold");
    a_hot_to_hold: assert property (junction_hot |-> ##2 (prot_mode == 4'h8))
        else $error("no hold after junction over-temperature");
    a_restart_min: assert property ($rose(restart_req) |-> $past(supply_at_min))
        else $error("restart without minimum supply");
    a_sat_pair: assert property ((pulse_end && sat_over_ref && prev_sat && !junction_hot
        && !ext_temp_trip) |-> ##[1:4] (prot_mode == 4'h4))
        else $error("no fast-recovery after two saturated pulses");
endmodule
bind pfp_fault_fsm pfp_fault_monitor i_pfp_fault_monitor (.hclk, .hresetn, .supply_ovp,
    .fb_ovp, .fb_open, .cs_res_fault, .sat_over_ref, .pulse_end, .junction_hot,
    .ext_temp_trip, .supply_at_min, .gate_out, .standby_draw, .supply_hold_floor,
    .restart_req, .prot_mode);

/* File: psr_fault_protection_fsm_tb_top.sv */
// Self-checking bench: register access and fault mode sequences
module psr_fault_protection_fsm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, v;
    logic [10:0] flt = 11'h004;
    logic [3:0] m;
    wire [31:0] hrdata;
    wire [3:0] prot_mode;
    wire hreadyout, hresp, gate_out, standby_draw, supply_hold_floor, restart_req, irq;
    wire pulse_req, pulse_end, supply_at_startup, supply_at_min;
    int errors = 0, compares = 0, cycles = 0;
    always #20 hclk = ~hclk;
    pfp_fault_fsm #(.SCP_CYCLES(20)) i_pfp_fault_fsm (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .supply_ovp(flt[0]), .fb_ovp(flt[1]), .fb_below_scp(flt[2]),
        .fb_open(flt[3]), .cs_res_fault(flt[4]), .sat_over_ref(flt[5]), .pulse_end,
        .junction_hot(flt[6]), .junction_cooled(flt[7]), .ext_temp_trip(flt[8]),
        .ext_temp_recover(flt[9]), .thermistor_present(flt[10]), .supply_at_startup,
        .supply_at_min, .pulse_req, .gate_out, .standby_draw, .supply_hold_floor,
        .restart_req, .prot_mode, .irq);
    pfp_analog_model i_pfp_analog_model (.hclk, .hresetn, .gate_out, .standby_draw,
        .supply_hold_floor, .restart_req, .pulse_req, .pulse_end, .supply_at_startup,
        .supply_at_min);
    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(0, a, 32'h0, r);
        chk($sformatf("register %h", a), exp, r);
    endtask
    task automatic setv(input logic [10:0] f);
        @(posedge hclk);
        flt <= f;
    endtask
    task automatic wait_mode(input logic [3:0] w);
        do @(negedge hclk); while (prot_mode !== w);
    endtask
    task automatic chk_mode(input logic [3:0] w, input int n);
        repeat (n) @(negedge hclk);
        chk("prot_mode", {28'h0, w}, {28'h0, prot_mode});
    endtask
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        rchk(8'h00, 32'h1);
        rchk(8'h08, 32'h0);
        rchk(8'h0C, 32'h0);
        rchk(8'h14, 32'd20);
        rchk(8'h20, 32'h0);
        chk("hresp", 32'h0, {31'h0, hresp});
        setv(11'h000);
        xfer(1, 8'h04, 32'hFF, v);
        xfer(1, 8'h0C, 32'h1F, v);
        rchk(8'h0C, 32'h1F);
        repeat (30) @(negedge hclk);
        rchk(8'h04, 32'h21);
        $display("test startup done");
        for (int i = 0; i < 6; i++)
        begin
            m = (i < 3) ? 4'h2 : 4'h4;
            setv(11'h001 << i);
            wait_mode(m);
            repeat (2) @(negedge hclk);
            chk("standby_draw", {31'h0, i < 3}, {31'h0, standby_draw});
            chk("irq", 32'h1, {31'h0, irq});
            rchk(8'h08, (i < 3) ? 32'h1 : 32'h2);
            do @(negedge hclk); while (restart_req !== 1'b1);
            chk_mode(m, 30);
            setv(11'h000);
            wait_mode(4'h1);
            rchk(8'h08, ((i < 3) ? 32'h1 : 32'h2) | 32'h8);
            xfer(1, 8'h08, 32'h1F, v);
            repeat (2) @(negedge hclk);
            chk("irq", 32'h0, {31'h0, irq});
            $display("test fault %0d done", i);
        end
        setv(11'h048);
        wait_mode(4'h8);
        chk_mode(4'h8, 100);
        chk("supply_hold_floor", 32'h1, {31'h0, supply_hold_floor});
        setv(11'h000);
        chk_mode(4'h8, 20);
        setv(11'h080);
        wait_mode(4'h1);
        rchk(8'h08, 32'h14);
        xfer(1, 8'h08, 32'h1F, v);
        $display("test junction hold done");
        xfer(1, 8'h00, 32'h3, v);
        setv(11'h500);
        wait_mode(4'h8);
        setv(11'h400);
        chk_mode(4'h8, 20);
        setv(11'h600);
        wait_mode(4'h1);
        setv(11'h100);
        chk_mode(4'h1, 50);
        setv(11'h140);
        wait_mode(4'h8);
        setv(11'h080);
        wait_mode(4'h1);
        $display("test external hold done");
        xfer(1, 8'h0C, 32'h0, v);
        xfer(1, 8'h08, 32'h1F, v);
        setv(11'h002);
        wait_mode(4'h2);
        repeat (2) @(negedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        rchk(8'h08, 32'h1);
        setv(11'h000);
        wait_mode(4'h1);
        $display("test mask done");
        complete_run();
    end
endmodule
